// File: design/drc_pkg.sv
package drc_pkg;
    // Delay taps offered to calibration for the resync sampling point
    localparam int PHASE_TAPS = 4;
    // Read pointer start distance behind the write pointer, in 2n words
    localparam int PTR_OFFSET = 4;
    // Cycles the core reset is held after a reset request edge
    localparam int RST_REQ_CYCLES = 16;
    // Stages of each reset synchroniser chain
    localparam int RST_SYNC_LEN = 2;
    // Value of the reset request counter when idle
    localparam logic [7:0] RST_CNT_IDLE = 8'h00;
    // Read pointer step per system enable in half and full rate builds
    localparam int STEP_HALF = 2;
    localparam int STEP_FULL = 1;
endpackage

// File: design/drc_read_capture.sv
`timescale 1ns/1ps
// Function
// RULE_01: Read data flows capture and resync, then demultiplex, then word alignment.
// RULE_02: Pin data is sampled by strobe then re-registered on the full-rate clock.
// RULE_03: Resync sampling tap comes from calibration; reads pass only after calibration.
// RULE_04: Widths grow n at pins, 2n after capture, 4n after demultiplexing.
// RULE_05: Half-rate build runs the system enable at half the memory clock.
// RULE_06: Dual-port RAM is written 2n wide and read 4n wide.
// RULE_07: Both RAM pointers advance every own cycle, never stalling.
// RULE_08: The RAM is the crossing element between resync and system timing.
// RULE_09: Full-rate RAM keeps 2n input width and halves the output width.
// RULE_10: Full-rate build uses the fast clock itself as the system rate.
// RULE_11: Full-rate resync path bypasses the clock divider.
// RULE_12: Outside party pulls global reset low to force a PLL relock.
// RULE_13: Optional reset request edge detector with reset counter.
// RULE_14: Divider has its own reset synchroniser, free of soft reset.
// RULE_15: Alignment places a whole transfer into one half-rate output word.
// RULE_16: Read pointer starts a fixed offset behind the write pointer.
// RULE_17: Pointers cleared in reset, released only after PLL lock.
module drc_read_capture #(
    parameter int DQ_W        = 8,
    parameter int RAM_AW      = 3,
    parameter bit HALF_RATE   = 1'b1,
    parameter bit USE_RST_REQ = 1'b1
) (
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              global_rst_n_i,
    input  wire logic                              reset_request_n_i,
    input  wire logic                              soft_rst_n_i,
    input  wire logic                              pll_locked_i,
    input  wire logic [DQ_W-1:0]                   captured_rise_data_i,
    input  wire logic [DQ_W-1:0]                   captured_fall_data_i,
    input  wire logic [1:0]                        cal_phase_i,
    input  wire logic                              cal_done_i,
    input  wire logic                              align_i,
    input  wire logic                              rd_ready_i,
    output logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0]    rd_data_o,
    output logic                                   rd_valid_o,
    output logic                                   buf_in_ready_o,
    output logic                                   overflow_o,
    output logic                                   sys_en_o,
    output logic                                   pll_reset_o,
    output logic                                   div_reset_o,
    output logic                                   phy_reset_o
);

    // Word widths after capture and after demultiplexing
    localparam int WW    = 2 * DQ_W;
    localparam int OUT_W = (HALF_RATE ? 4 : 2) * DQ_W;
    localparam int STEP  = HALF_RATE ? drc_pkg::STEP_HALF : drc_pkg::STEP_FULL;
    localparam int SL    = drc_pkg::RST_SYNC_LEN;
    // Entries in the demultiplexing RAM; must hold the pointer gap with room
    localparam int DEPTH = 1 << RAM_AW;

    typedef struct packed {
        // Capture stages and the tap line
        logic [WW-1:0]                          d_s1;
        logic [WW-1:0]                          d_s2;
        logic [drc_pkg::PHASE_TAPS-1:0][WW-1:0] tap;
        // Pin synchronisers
        logic                                   g_s1;
        logic                                   g_s2;
        logic                                   q_s1;
        logic                                   q_s2;
        logic                                   q_s3;
        logic                                   s_s1;
        logic                                   s_s2;
        logic                                   l_s1;
        logic                                   l_s2;
        // Reset management
        logic [7:0]                             rcnt;
        logic [SL-1:0]                          div_sync;
        logic [SL-1:0]                          phy_sync;
        logic                                   pll_rst;
        logic                                   div_rst;
        logic                                   phy_rst;
        // Rate enable, pointers and calibration
        logic                                   en;
        logic [RAM_AW-1:0]                      wptr;
        logic [RAM_AW-1:0]                      rptr;
        logic                                   cal;
        // Two-entry output buffer
        logic [OUT_W-1:0]                       b0;
        logic [OUT_W-1:0]                       b1;
        logic                                   v0;
        logic                                   v1;
        logic                                   rdy;
        logic                                   ovf;
    } drc_state_s;

    drc_state_s        st_r;
    drc_state_s        st_nxt;
    logic [WW-1:0]     ram [0:DEPTH-1];
    logic [WW-1:0]     wdata;
    logic [RAM_AW-1:0] rbase;
    logic [OUT_W-1:0]  rword;
    logic              push;
    logic              pop;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pointer step with wrap; the RAM depth is a power of two by construction
    function automatic logic [RAM_AW-1:0] ptr_add(
        input logic [RAM_AW-1:0] ptr,
        input int                step
    );
        ptr_add = ptr + RAM_AW'(step);
    endfunction

    // Shift one stage into a reset synchroniser chain
    function automatic logic [SL-1:0] sync_shift(
        input logic [SL-1:0] chain,
        input logic          din
    );
        sync_shift = {chain[SL-2:0], din};
    endfunction

    // A chain holds its reset until a one reaches the last stage
    function automatic logic sync_reset(
        input logic [SL-1:0] chain
    );
        sync_reset = !chain[SL-1];
    endfunction

    // The request counter is idle once it has run down
    function automatic logic cnt_idle(
        input logic [7:0] cnt
    );
        cnt_idle = (cnt == drc_pkg::RST_CNT_IDLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Demultiplexing RAM and its read side

    // Resync word comes from the calibrated tap, not a fixed stage
    assign wdata = st_r.tap[cal_phase_i]; // RULE_03
    // Alignment shifts the read base by one 2n word
    assign rbase = ptr_add(st_r.rptr, int'(align_i)); // RULE_15

    // Written every fast cycle outside core reset; the pointer gap is what crosses timing
    // Contents are not reset; words before calibration are never pushed out
    always_ff @(posedge clk_i) begin
        if (!st_r.phy_rst) begin
            ram[st_r.wptr] <= wdata; // RULE_06 RULE_08
        end
    end

    generate
        if (HALF_RATE) begin : g_half
            // Two consecutive 2n words form one 4n half-rate word
            always_comb begin
                // Read is combinational; the output buffer registers it
                rword = {ram[ptr_add(rbase, 1)], ram[rbase]}; // RULE_04 RULE_06
            end
        end else begin : g_full
            // Full rate reads one 2n word, half the half-rate output
            always_comb begin
                rword = ram[rbase]; // RULE_09
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        // Fields not assigned below keep their value
        st_nxt = st_r;

        // Pin data sampled then re-registered on the free-running clock
        st_nxt.d_s1 = {captured_fall_data_i, captured_rise_data_i}; // RULE_02
        st_nxt.d_s2 = st_r.d_s1; // RULE_02
        // Tap line offers the sampling points calibration chooses from
        st_nxt.tap  = {st_r.tap[drc_pkg::PHASE_TAPS-2:0], st_r.d_s2}; // RULE_01 RULE_03

        // Asynchronous pins pass two flops before use
        // Global reset pin
        st_nxt.g_s1 = global_rst_n_i;
        st_nxt.g_s2 = st_r.g_s1;
        // Reset request pin; the third stage exists only for edge detection
        st_nxt.q_s1 = reset_request_n_i;
        st_nxt.q_s2 = st_r.q_s1;
        st_nxt.q_s3 = st_r.q_s2;
        // Soft reset pin, core chain only
        st_nxt.s_s1 = soft_rst_n_i;
        st_nxt.s_s2 = st_r.s_s1;
        // PLL lock pin; lock may drop at any time, so it is a level
        st_nxt.l_s1 = pll_locked_i;
        st_nxt.l_s2 = st_r.l_s1;

        // Global reset low holds the PLL in reset until released
        st_nxt.pll_rst = !st_r.g_s2; // RULE_12

        // Falling edge of reset request restarts the hold counter
        // A request held low counts once; only the edge restarts the hold
        if (USE_RST_REQ && st_r.q_s3 && !st_r.q_s2) begin
            st_nxt.rcnt = 8'(drc_pkg::RST_REQ_CYCLES); // RULE_13
        end else if (!cnt_idle(st_r.rcnt)) begin
            st_nxt.rcnt = st_r.rcnt - 8'h01; // RULE_13
        end

        // Divider chain sees global reset only; soft reset must not stop it
        st_nxt.div_sync = sync_shift(st_r.div_sync, st_r.g_s2); // RULE_14
        st_nxt.div_rst  = sync_reset(st_r.div_sync); // RULE_14
        // Core chain also takes soft reset, request and PLL lock
        // Global reset, soft reset or lock low, or a running request count, drops a zero into the chain at once
        st_nxt.phy_sync = sync_shift(st_r.phy_sync,
                                     st_r.g_s2 & st_r.s_s2 & st_r.l_s2 &
                                     cnt_idle(st_r.rcnt)); // RULE_17
        st_nxt.phy_rst  = sync_reset(st_r.phy_sync); // RULE_17

        // Half rate toggles the enable; full rate runs every fast cycle
        // The divider starts only once its own reset chain has released
        if (st_r.div_rst) begin
            st_nxt.en = 1'b0;
        end else if (HALF_RATE) begin
            st_nxt.en = !st_r.en; // RULE_05
        end else begin
            st_nxt.en = 1'b1; // RULE_10 RULE_11
        end

        // Pointers held in reset, then run free at a fixed gap
        // The read pointer starts behind so its first reads find written words
        if (st_r.phy_rst) begin
            st_nxt.wptr = '0; // RULE_17
            st_nxt.rptr = ptr_add(RAM_AW'(0), -drc_pkg::PTR_OFFSET); // RULE_16
            st_nxt.cal  = 1'b0;
        end else begin
            // No stall input exists on purpose: the gap must never drift
            st_nxt.wptr = ptr_add(st_r.wptr, 1); // RULE_07
            if (st_r.en) begin
                st_nxt.rptr = ptr_add(st_r.rptr, STEP); // RULE_07
            end
            st_nxt.cal = st_r.cal | cal_done_i; // RULE_03
        end

        // Output buffer; its fill side cannot stall the pointers
        // One word per system enable once calibration has finished
        push = st_r.cal && st_r.en && !st_r.phy_rst;
        // The receiver takes the head word when it is ready
        pop  = st_r.v0 && rd_ready_i;
        // Head moves up first, so a push lands behind what is left
        if (pop) begin
            st_nxt.b0 = st_r.b1;
            st_nxt.v0 = st_r.v1;
            st_nxt.v1 = 1'b0;
        end
        if (push && !st_r.v1) begin
            if (!st_nxt.v0) begin
                st_nxt.b0 = rword;
                st_nxt.v0 = 1'b1;
            end else begin
                st_nxt.b1 = rword;
                st_nxt.v1 = 1'b1;
            end
        end
        // A word arriving at a full buffer is lost; the flag sticks
        if (push && st_r.v1) begin
            st_nxt.ovf = 1'b1;
        end
        // Core reset empties the buffer
        if (st_r.phy_rst) begin
            st_nxt.v0 = 1'b0;
            st_nxt.v1 = 1'b0;
        end
        // Ready is taken from the next fill, so it never lags a fill
        st_nxt.rdy = !st_nxt.v1;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Reset asserts every reset output so nothing runs before release
    // Request stages reset high so that release is not seen as a request edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r         <= '0;
            st_r.pll_rst <= 1'b1;
            st_r.div_rst <= 1'b1;
            st_r.phy_rst <= 1'b1;
            st_r.q_s1    <= 1'b1;
            st_r.q_s2    <= 1'b1;
            st_r.q_s3    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    // No logic sits after the register; buffer valid and ready leave separately
    assign rd_data_o      = st_r.b0;
    assign rd_valid_o     = st_r.v0;
    assign buf_in_ready_o = st_r.rdy;
    assign overflow_o     = st_r.ovf;
    assign sys_en_o       = st_r.en;
    assign pll_reset_o    = st_r.pll_rst;
    assign div_reset_o    = st_r.div_rst;
    assign phy_reset_o    = st_r.phy_rst;

endmodule

// File: tb/drc_read_capture_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module drc_read_capture_chk #(
    parameter int DQ_W      = 8,
    parameter bit HALF_RATE = 1'b1
) (
    input wire logic                                clk_i,
    input wire logic                                rst_i,
    input wire logic                                global_rst_n_i,
    input wire logic                                reset_request_n_i,
    input wire logic                                soft_rst_n_i,
    input wire logic                                pll_locked_i,
    input wire logic                                cal_done_i,
    input wire logic                                rd_ready_i,
    input wire logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] rd_data_o,
    input wire logic                                rd_valid_o,
    input wire logic                                overflow_o,
    input wire logic                                sys_en_o,
    input wire logic                                pll_reset_o,
    input wire logic                                div_reset_o,
    input wire logic                                phy_reset_o
);
    logic cal_seen_r;
    // Own sticky copy of calibration done, since words before it are unaligned junk
    always_ff @(posedge clk_i) begin
        cal_seen_r <= !rst_i && (cal_seen_r || cal_done_i);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    rst_hold_a: assert property ($fell(rst_i) |-> phy_reset_o && div_reset_o)
        else $error("reset released too early");
    pll_relock_a: assert property ($fell(global_rst_n_i) |-> ##[1:4] pll_reset_o)
        else $error("pll not held on global reset");
    soft_core_a: assert property (!soft_rst_n_i |-> ##[1:5] phy_reset_o)
        else $error("soft reset missed core");
    div_free_a: assert property ((global_rst_n_i && pll_locked_i)[*6] ##0 !div_reset_o
        |=> !div_reset_o) else $error("divider reset by core source");
    lock_core_a: assert property (!pll_locked_i |-> ##[1:5] phy_reset_o)
        else $error("core runs without lock");
    req_hold_a: assert property ($fell(reset_request_n_i) |-> ##8 phy_reset_o[*8])
        else $error("request reset too short");
    reset_quiet_a: assert property (phy_reset_o[*2] |-> !rd_valid_o)
        else $error("word during core reset");
    word_stand_a: assert property (rd_valid_o && !rd_ready_i ##1 !phy_reset_o
        |-> rd_valid_o && $stable(rd_data_o)) else $error("word changed while stalled");
    ovf_sticky_a: assert property (overflow_o |=> overflow_o)
        else $error("overflow cleared");
    cal_gate_a: assert property (!cal_seen_r |-> !rd_valid_o)
        else $error("word before calibration");
    en_rate_a: assert property (!div_reset_o && !$past(div_reset_o)
        |-> sys_en_o == (HALF_RATE ? !$past(sys_en_o) : 1'b1)) else $error("system enable rate");
    cover property (rd_valid_o && rd_ready_i);
    cover property (overflow_o);
    cover property ($fell(phy_reset_o));
endmodule

// File: tb/drc_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module drc_mem_model #(
    parameter int DQ_W = 8
) (
    input  wire logic            clk_i,
    input  wire logic            burst_i,
    output logic      [DQ_W-1:0] rise_o,
    output logic      [DQ_W-1:0] fall_o
);
    logic [DQ_W-1:0] cnt = '0;
    initial begin
        rise_o = '0;
        fall_o = '0;
    end
    // One beat per edge pair: rise carries 2k, fall 2k+1; idle lines never keep old data
    always @(posedge clk_i) begin
        #1;
        if (burst_i) begin
            rise_o = cnt;
            fall_o = cnt + 1'b1;
            cnt = cnt + 2'h2;
        end else begin
            rise_o = ~rise_o;
            fall_o = ~fall_o;
        end
    end
endmodule

// File: tb/drc_read_capture_tb.sv
`timescale 1ns/1ps
module drc_read_capture_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, global_rst_n_i = 1'b1, reset_request_n_i = 1'b1;
    logic        soft_rst_n_i = 1'b1, pll_locked_i = 1'b1, cal_done_i = 1'b0, align_i = 1'b0;
    logic        rd_ready_i = 1'b0, burst = 1'b0, rd_valid_o, buf_in_ready_o, overflow_o;
    logic        sys_en_o, pll_reset_o, div_reset_o, phy_reset_o;
    logic [1:0]  cal_phase_i = 2'h0;
    logic [7:0]  captured_rise_data_i, captured_fall_data_i;
    logic [31:0] rd_data_o;
    int          n_mismatch = 0, n_checks = 0, cyc = 0;
    drc_read_capture #(.DQ_W(8)) drc_read_capture_i (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .global_rst_n_i       (global_rst_n_i),
        .reset_request_n_i    (reset_request_n_i),
        .soft_rst_n_i         (soft_rst_n_i),
        .pll_locked_i         (pll_locked_i),
        .captured_rise_data_i (captured_rise_data_i),
        .captured_fall_data_i (captured_fall_data_i),
        .cal_phase_i          (cal_phase_i),
        .cal_done_i           (cal_done_i),
        .align_i              (align_i),
        .rd_ready_i           (rd_ready_i),
        .rd_data_o            (rd_data_o),
        .rd_valid_o           (rd_valid_o),
        .buf_in_ready_o       (buf_in_ready_o),
        .overflow_o           (overflow_o),
        .sys_en_o             (sys_en_o),
        .pll_reset_o          (pll_reset_o),
        .div_reset_o          (div_reset_o),
        .phy_reset_o          (phy_reset_o)
    );
    drc_mem_model #(.DQ_W(8)) drc_mem_model_i (.clk_i(clk_i), .burst_i(burst),
        .rise_o(captured_rise_data_i), .fall_o(captured_fall_data_i));
    initial forever #2 clk_i = ~clk_i;
    // Cut a hang short well beyond the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_core();
        for (int i = 0; i < 60 && phy_reset_o !== 1'b0; i++) tick(1);
        chk("core reset", {31'h0, phy_reset_o}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_boot();
        tick(16);
        rst_i = 1'b0;
        burst = 1'b1;
        wait_core();
        chk("pll reset", {31'h0, pll_reset_o}, 32'h0);
        chk("div reset", {31'h0, div_reset_o}, 32'h0);
        repeat (20) begin
            tick(1);
            chk("early word", {31'h0, rd_valid_o}, 32'h0);
        end
    endtask
    // Every tap and a realignment; each word looked at while it stands
    task automatic t_stream();
        logic [7:0] b;
        logic [7:0] c0;
        logic [7:0] cw;
        int         gap;
        cal_done_i = 1'b1;
        rd_ready_i = 1'b1;
        for (int k = 0; k < 5; k++) begin
            cal_phase_i = k[1:0];
            align_i = (k == 4);
            tick(16);
            for (int w = 0; w < 6; w++) begin
                gap = 0;
                do begin
                    tick(1);
                    gap++;
                end while (rd_valid_o !== 1'b1 && gap < 20);
                if (w > 0) chk("spacing", 32'(gap), 32'h2);
                if (w > 0) chk("step", {24'h0, rd_data_o[7:0]}, {24'h0, b + 8'h4});
                b = rd_data_o[7:0];
                chk("pairing", rd_data_o, {b + 8'h3, b + 8'h2, b + 8'h1, b});
                // A later tap is one word older; realignment is one word newer
                cw = b - 8'(2 * cyc) + 8'(2 * (k % 4)) - 8'(2 * int'(align_i));
                if (k == 0 && w == 0) c0 = cw;
                chk("tap and align", {24'h0, cw}, {24'h0, c0});
            end
        end
    endtask
    task automatic t_stall();
        logic [31:0] held;
        rd_ready_i = 1'b0;
        tick(4);
        held = rd_data_o;
        tick(30);
        chk("held word", rd_data_o, held);
        chk("buf ready", {31'h0, buf_in_ready_o}, 32'h0);
        chk("overflow", {31'h0, overflow_o}, 32'h1);
        rd_ready_i = 1'b1;
        tick(10);
        chk("overflow kept", {31'h0, overflow_o}, 32'h1);
    endtask
    task automatic t_core_rst();
        for (int k = 0; k < 2; k++) begin
            soft_rst_n_i = (k != 0);
            pll_locked_i = (k == 0);
            tick(6);
            chk("core held", {31'h0, phy_reset_o}, 32'h1);
            if (k == 0) chk("div free", {31'h0, div_reset_o}, 32'h0);
            soft_rst_n_i = 1'b1;
            pll_locked_i = 1'b1;
            wait_core();
        end
    endtask
    task automatic t_req();
        int n = 0;
        reset_request_n_i = 1'b0;
        tick(2);
        reset_request_n_i = 1'b1;
        repeat (40) begin
            tick(1);
            n += (phy_reset_o === 1'b1);
        end
        chk("request hold", 32'(n >= 16 && n <= 24), 32'h1);
    endtask
    task automatic t_global();
        global_rst_n_i = 1'b0;
        tick(5);
        chk("pll held", {31'h0, pll_reset_o}, 32'h1);
        global_rst_n_i = 1'b1;
        wait_core();
        chk("pll released", {31'h0, pll_reset_o}, 32'h0);
        rst_i = 1'b1;
        tick(2);
        chk("overflow reset", {31'h0, overflow_o}, 32'h0);
        rst_i = 1'b0;
        tick(2);
        chk("pll held after release", {31'h0, pll_reset_o}, 32'h1);
        chk("core held after release", {31'h0, phy_reset_o}, 32'h1);
        wait_core();
    endtask
    initial begin
        t_boot();
        t_stream();
        t_stall();
        t_core_rst();
        t_req();
        t_global();
        end_sim();
    end
endmodule
bind drc_read_capture drc_read_capture_chk #(.DQ_W(DQ_W), .HALF_RATE(HALF_RATE))
    drc_read_capture_chk_i (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .global_rst_n_i    (global_rst_n_i),
    .reset_request_n_i (reset_request_n_i),
    .soft_rst_n_i      (soft_rst_n_i),
    .pll_locked_i      (pll_locked_i),
    .cal_done_i        (cal_done_i),
    .rd_ready_i        (rd_ready_i),
    .rd_data_o         (rd_data_o),
    .rd_valid_o        (rd_valid_o),
    .overflow_o        (overflow_o),
    .sys_en_o          (sys_en_o),
    .pll_reset_o       (pll_reset_o),
    .div_reset_o       (div_reset_o),
    .phy_reset_o       (phy_reset_o)
);
